// ### shared/pce_pkg.sv
/*
 * Constants shared by the cutoff and event-link logic: register byte
 * offsets, field positions, reset values and mode codes.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */

package pce_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FUNC = 8'h00;
    localparam logic [7:0] ADDR_OUT_EN = 8'h04;
    localparam logic [7:0] ADDR_CUT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_LVL0 = 8'h0c;
    localparam logic [7:0] ADDR_LVL1 = 8'h10;
    localparam logic [7:0] ADDR_OPTION = 8'h14;
    localparam logic [7:0] ADDR_ELINK = 8'h18;
    localparam logic [7:0] ADDR_RUN = 8'h1c;
    localparam logic [7:0] ADDR_CH_STAT = 8'h20;
    localparam logic [7:0] ADDR_CAP0 = 8'h24;
    localparam logic [7:0] ADDR_CAP1 = 8'h28;
    localparam logic [7:0] ADDR_STATE = 8'h2c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CUT_PTO_BIT = 0;
    localparam int CUT_STATUS_BIT = 7;
    localparam int OPT_OCM_BIT = 0;
    localparam int OPT_HIZ_BIT = 1;
    localparam int EL_SEL0_BIT = 0;
    localparam int EL_SEL1_BIT = 1;
    localparam int EL_CEN0_BIT = 2;
    localparam int EL_CEN1_BIT = 3;

    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] OUT_EN_RST = 8'hff;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] MODE_CAPTURE = 3'h0;
    localparam logic [2:0] MODE_COMPARE = 3'h1;
    localparam logic [2:0] MODE_PWM = 3'h2;
    localparam logic [2:0] MODE_RSYNC = 3'h3;
    localparam logic [2:0] MODE_COMPL = 3'h4;
    localparam logic [2:0] MODE_TRI = 3'h5;
    localparam logic [1:0] LVL_LOW = 2'h2;
    localparam logic [1:0] LVL_HIGH = 2'h3;

    // True in the four pulse output modes
    function automatic logic is_pulse_mode(input logic [2:0] m);
        is_pulse_mode = (m == MODE_PWM) || (m == MODE_RSYNC) || (m == MODE_COMPL) || (m == MODE_TRI);
    endfunction

    // True where comparator hi-Z cutoff may act
    function automatic logic is_cmp_mode(input logic [2:0] m);
        is_cmp_mode = (m == MODE_RSYNC) || (m == MODE_COMPL);
    endfunction

endpackage

// ### logic/pce_pin_force.sv
/*
 * One timer output pin: picks the normal waveform, the cutoff level or
 * hi-Z, and registers the result.
 * Assumes its control inputs are synchronous to pclk.
 */
`timescale 1ns/1ps

module pce_pin_force (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic timer_en,
    input wire logic timer_level,
    input wire logic force_cut,
    input wire logic force_hiz,
    input wire logic [1:0] level_code,
    // Pin
    output logic pin_out,
    output logic pin_oe
);

    logic nxt_out;
    logic nxt_oe;
    logic pin_out_ff;
    logic pin_oe_ff;

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    // Comparator cutoff outranks level cutoff since it only knows hi-Z
    assign nxt_oe = timer_en && !force_hiz && (!force_cut || level_code == pce_pkg::LVL_LOW
        || level_code == pce_pkg::LVL_HIGH);
    assign nxt_out = !nxt_oe ? 1'b0 : force_cut ? (level_code == pce_pkg::LVL_HIGH) : timer_level;

    // Registered so the forced state appears on the clock after detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else begin
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
        end
    end

    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;

endmodule

// ### logic/pce_event_route.sv
/*
 * Event outputs toward the event link controller: picks capture edges or
 * compare matches by mode and adds the underflow event.
 * Assumes one-cycle pulse inputs from the counter logic.
 */
`timescale 1ns/1ps

module pce_event_route (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Sources, order A0 B0 A1 B1
    input wire logic [2:0] mode,
    input wire logic [3:0] cap_edge,
    input wire logic [3:0] cmp_match,
    input wire logic ch1_underflow,
    // Events
    output logic [4:0] link_event
);

    logic is_cap;
    logic [4:0] nxt_event;
    logic [4:0] event_ff;

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    // C and D sources are never brought in, so they cannot make events
    assign is_cap = (mode == pce_pkg::MODE_CAPTURE);
    assign nxt_event[3:0] = is_cap ? cap_edge : cmp_match;
    assign nxt_event[4] = (mode == pce_pkg::MODE_COMPL) && ch1_underflow;

    // One-cycle pulses, delayed one clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_ff <= 5'h00;
        end else begin
            event_ff <= nxt_event;
        end
    end

    assign link_event = event_ff;

endmodule

// ### logic/pce_cutoff_top.sv
/*
 * Forced cutoff and event-link logic for a two-channel timer, with its
 * control registers on APB.
 * Assumes timer waveforms, match, edge and underflow pulses come from the
 * counter logic, and all inputs are synchronous to pclk.
 */
`timescale 1ns/1ps

module pce_cutoff_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Cutoff sources
    input wire logic ext_cutoff_irq_pin_n,
    input wire logic cmp_overcurrent,
    input wire logic event_in0,
    input wire logic event_in1,
    // Timer side, pins ordered A0 B0 C0 D0 A1 B1 C1 D1
    input wire logic [7:0] timer_wave,
    input wire logic [15:0] counter0,
    input wire logic [15:0] counter1,
    input wire logic [3:0] cap_edge,
    input wire logic [3:0] cmp_match,
    input wire logic ch1_underflow,
    // Pins
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // Counter control and events
    output logic [1:0] count_run,
    output logic [4:0] link_event
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [2:0] function_ctrl_reg_ff;
    logic [7:0] output_enable_reg_ff;
    logic pin_cutoff_enable_ff;
    logic cutoff_status_ff;
    logic [7:0] ch0_cutoff_level_cfg_ff;
    logic [7:0] ch1_cutoff_level_cfg_ff;
    logic overcurrent_mode_sel_ff;
    logic hiz_select_ff;
    logic [3:0] event_link_ctrl_reg_ff;
    logic [1:0] count_run_ff;
    logic [1:0] match_capture_flag_d_ff;
    logic [15:0] cap_d0_ff;
    logic [15:0] cap_d1_ff;
    logic event_cut_ff;
    logic cmp_cut_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic ext_cut_now;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic wr_take;
    logic addr_hit;
    logic [31:0] rd_mux;
    logic wr_func;
    logic wr_out_en;
    logic wr_cut;
    logic wr_lvl0;
    logic wr_lvl1;
    logic wr_opt;
    logic wr_elink;
    logic wr_run;
    logic wr_stat;

    // Request is taken in the access phase, which this slave always ends at once
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pready_ff && pwrite && !pslverr_ff;
    assign wr_func = wr_take && (paddr == pce_pkg::ADDR_FUNC);
    assign wr_out_en = wr_take && (paddr == pce_pkg::ADDR_OUT_EN);
    assign wr_cut = wr_take && (paddr == pce_pkg::ADDR_CUT_CTRL);
    assign wr_lvl0 = wr_take && (paddr == pce_pkg::ADDR_LVL0);
    assign wr_lvl1 = wr_take && (paddr == pce_pkg::ADDR_LVL1);
    assign wr_opt = wr_take && (paddr == pce_pkg::ADDR_OPTION);
    assign wr_elink = wr_take && (paddr == pce_pkg::ADDR_ELINK);
    assign wr_run = wr_take && (paddr == pce_pkg::ADDR_RUN);
    assign wr_stat = wr_take && (paddr == pce_pkg::ADDR_CH_STAT);

    // Read mux; unused upper bits read zero
    always_comb begin
        addr_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            pce_pkg::ADDR_FUNC: rd_mux[2:0] = function_ctrl_reg_ff;
            pce_pkg::ADDR_OUT_EN: rd_mux[7:0] = output_enable_reg_ff;
            pce_pkg::ADDR_CUT_CTRL: begin
                rd_mux[pce_pkg::CUT_PTO_BIT] = pin_cutoff_enable_ff;
                rd_mux[pce_pkg::CUT_STATUS_BIT] = cutoff_status_ff;
            end
            pce_pkg::ADDR_LVL0: rd_mux[7:0] = ch0_cutoff_level_cfg_ff;
            pce_pkg::ADDR_LVL1: rd_mux[7:0] = ch1_cutoff_level_cfg_ff;
            pce_pkg::ADDR_OPTION: begin
                rd_mux[pce_pkg::OPT_OCM_BIT] = overcurrent_mode_sel_ff;
                rd_mux[pce_pkg::OPT_HIZ_BIT] = hiz_select_ff;
            end
            pce_pkg::ADDR_ELINK: rd_mux[3:0] = event_link_ctrl_reg_ff;
            pce_pkg::ADDR_RUN: rd_mux[1:0] = count_run_ff;
            pce_pkg::ADDR_CH_STAT: rd_mux[1:0] = match_capture_flag_d_ff;
            pce_pkg::ADDR_CAP0: rd_mux[15:0] = cap_d0_ff;
            pce_pkg::ADDR_CAP1: rd_mux[15:0] = cap_d1_ff;
            pce_pkg::ADDR_STATE: rd_mux[2:0] = {cmp_cut_ff, event_cut_ff, ext_cut_now};
            default: addr_hit = 1'b0;
        endcase
    end

    // Answer prepared in setup, shown for the single access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase && !addr_hit;
            prdata_ff <= (setup_phase && !pwrite && addr_hit) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Cutoff conditions
    // ------------------------------------------------------------
    logic pulse_mode;
    logic event_trig;
    logic cmp_trig;
    logic status_clear;
    logic cut_any;
    logic cap_mode;
    logic [1:0] cap_trig;

    assign pulse_mode = pce_pkg::is_pulse_mode(function_ctrl_reg_ff);
    // Level driven: ends as soon as the pin returns high
    assign ext_cut_now = pulse_mode && pin_cutoff_enable_ff && !ext_cutoff_irq_pin_n;
    // Event cutoff ignored outside the pulse modes, so never in capture mode
    assign event_trig = pulse_mode && ((event_in0 && event_link_ctrl_reg_ff[pce_pkg::EL_SEL0_BIT]
        && event_link_ctrl_reg_ff[pce_pkg::EL_CEN0_BIT]) || (event_in1
        && event_link_ctrl_reg_ff[pce_pkg::EL_SEL1_BIT]
        && event_link_ctrl_reg_ff[pce_pkg::EL_CEN1_BIT]));
    assign cmp_trig = pce_pkg::is_cmp_mode(function_ctrl_reg_ff) && overcurrent_mode_sel_ff
        && hiz_select_ff && cmp_overcurrent;
    // Release only counts while both counters are stopped
    assign status_clear = wr_cut && !pwdata[pce_pkg::CUT_STATUS_BIT] && (count_run_ff == 2'b00);
    assign cut_any = ext_cut_now || event_cut_ff;

    // Status sets on pin or event cutoff; a set in the clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cutoff_status_ff <= 1'b0;
        end else if (ext_cut_now || event_trig) begin
            cutoff_status_ff <= 1'b1;
        end else if (status_clear) begin
            cutoff_status_ff <= 1'b0;
        end
    end

    // Latched cutoffs: a single event holds until software releases it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_cut_ff <= 1'b0;
            cmp_cut_ff <= 1'b0;
        end else begin
            event_cut_ff <= event_trig || (event_cut_ff && !status_clear);
            cmp_cut_ff <= cmp_trig || (cmp_cut_ff && !status_clear);
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            function_ctrl_reg_ff <= pce_pkg::MODE_RST;
            output_enable_reg_ff <= pce_pkg::OUT_EN_RST;
        end else begin
            if (wr_func) function_ctrl_reg_ff <= pwdata[2:0];
            if (wr_out_en) output_enable_reg_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_cutoff_enable_ff <= 1'b0;
            ch0_cutoff_level_cfg_ff <= 8'h00;
            ch1_cutoff_level_cfg_ff <= 8'h00;
        end else begin
            if (wr_cut) pin_cutoff_enable_ff <= pwdata[pce_pkg::CUT_PTO_BIT];
            if (wr_lvl0) ch0_cutoff_level_cfg_ff <= pwdata[7:0];
            if (wr_lvl1) ch1_cutoff_level_cfg_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overcurrent_mode_sel_ff <= 1'b0;
            hiz_select_ff <= 1'b0;
            event_link_ctrl_reg_ff <= 4'h0;
        end else begin
            if (wr_opt) overcurrent_mode_sel_ff <= pwdata[pce_pkg::OPT_OCM_BIT];
            if (wr_opt) hiz_select_ff <= pwdata[pce_pkg::OPT_HIZ_BIT];
            if (wr_elink) event_link_ctrl_reg_ff <= pwdata[3:0];
        end
    end

    // Run bits go straight to the counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_run_ff <= 2'b00;
        end else if (wr_run) begin
            count_run_ff <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Event capture into the D registers
    // ------------------------------------------------------------
    assign cap_mode = (function_ctrl_reg_ff == pce_pkg::MODE_CAPTURE);
    assign cap_trig[0] = cap_mode && event_in0 && event_link_ctrl_reg_ff[pce_pkg::EL_SEL0_BIT];
    assign cap_trig[1] = cap_mode && event_in1 && event_link_ctrl_reg_ff[pce_pkg::EL_SEL1_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_d0_ff <= 16'h0000;
            cap_d1_ff <= 16'h0000;
        end else begin
            if (cap_trig[0]) cap_d0_ff <= counter0;
            if (cap_trig[1]) cap_d1_ff <= counter1;
        end
    end

    // Flags clear on a written 0; a capture in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_capture_flag_d_ff <= 2'b00;
        end else begin
            match_capture_flag_d_ff <= cap_trig | (match_capture_flag_d_ff & ~(wr_stat ? ~pwdata[1:0] : 2'b00));
        end
    end

    // ------------------------------------------------------------
    // Pin stages and event outputs
    // ------------------------------------------------------------
    logic [15:0] lvl_all;

    assign lvl_all = {ch1_cutoff_level_cfg_ff, ch0_cutoff_level_cfg_ff};

    // Enable bit 0 means timer drives the pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            pce_pin_force u_pin (
                .pclk(pclk),
                .presetn(presetn),
                .timer_en(!output_enable_reg_ff[gi]),
                .timer_level(timer_wave[gi]),
                .force_cut(cut_any),
                .force_hiz(cmp_cut_ff),
                .level_code(lvl_all[2*gi +: 2]),
                .pin_out(pin_out[gi]),
                .pin_oe(pin_oe[gi])
            );
        end
    endgenerate

    pce_event_route u_events (
        .pclk(pclk),
        .presetn(presetn),
        .mode(function_ctrl_reg_ff),
        .cap_edge(cap_edge),
        .cmp_match(cmp_match),
        .ch1_underflow(ch1_underflow),
        .link_event(link_event)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign count_run = count_run_ff;

endmodule

// ### verif/pce_cutoff_sva.sv
/* Checker on the top-level ports of the cutoff block.
   Assumes APB writes land at the access edge. */
`timescale 1ns/1ps

module pce_cutoff_sva (
    // Clock, reset and APB
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic pready,
    // Sources
    input logic ext_cutoff_irq_pin_n,
    input logic cmp_overcurrent,
    input logic [3:0] cap_edge,
    input logic [3:0] cmp_match,
    input logic ch1_underflow,
    // Outputs
    input logic [7:0] pin_out,
    input logic [7:0] pin_oe,
    input logic [1:0] count_run,
    input logic [4:0] link_event
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Shadow copies of the control fields
    // ------------------------------------------------------------
    logic [2:0] mode_ff;
    logic [7:0] oen_ff;
    logic pto_ff;
    logic [1:0] opt_ff;
    logic [1:0] lvl_ff;
    wire wr = psel & penable & pready & pwrite;
    wire pulse_m = mode_ff inside {pce_pkg::MODE_PWM, pce_pkg::MODE_RSYNC, pce_pkg::MODE_COMPL, pce_pkg::MODE_TRI};
    wire cmp_m = mode_ff inside {pce_pkg::MODE_RSYNC, pce_pkg::MODE_COMPL};

    // Follows the slave's write strobe without its pslverr gate, so no skew against it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= pce_pkg::MODE_RST;
            oen_ff <= pce_pkg::OUT_EN_RST;
            pto_ff <= 1'b0;
            opt_ff <= 2'h0;
            lvl_ff <= 2'h0;
        end else if (wr) begin
            if (paddr == pce_pkg::ADDR_FUNC) mode_ff <= pwdata[2:0];
            if (paddr == pce_pkg::ADDR_OUT_EN) oen_ff <= pwdata[7:0];
            if (paddr == pce_pkg::ADDR_CUT_CTRL) pto_ff <= pwdata[0];
            if (paddr == pce_pkg::ADDR_OPTION) opt_ff <= pwdata[1:0];
            if (paddr == pce_pkg::ADDR_LVL0) lvl_ff <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    ev_match_a:
    assert property (mode_ff != pce_pkg::MODE_CAPTURE && cmp_match[0] |=> link_event[0]) else $error("match event lost");
    ev_capture_a:
    assert property (mode_ff == pce_pkg::MODE_CAPTURE && cap_edge[1] |=> link_event[1]) else $error("edge event lost");
    ev_underflow_a:
    assert property (ch1_underflow |=> link_event[4] == ($past(mode_ff) == pce_pkg::MODE_COMPL))
        else $error("underflow event wrong");
    ev_quiet_a:
    assert property (cap_edge == 4'h0 && cmp_match == 4'h0 |=> link_event[3:0] == 4'h0) else $error("spurious event");
    pin_disabled_a:
    assert property (oen_ff != 8'h00 |=> (pin_oe & $past(oen_ff)) == 8'h00) else $error("disabled pin driven");
    cmp_hiz_a:
    assert property (cmp_m && opt_ff == 2'h3 && cmp_overcurrent |-> ##[1:3] pin_oe == 8'h00)
        else $error("cmp cutoff not hi-Z");
    ext_cut_a:
    assert property (pulse_m && pto_ff && !ext_cutoff_irq_pin_n && !oen_ff[0] && lvl_ff == pce_pkg::LVL_LOW
        |=> pin_oe[0] && !pin_out[0]) else $error("pin cutoff level wrong");
    run_write_a:
    assert property (wr && paddr == pce_pkg::ADDR_RUN |=> count_run == $past(pwdata[1:0])) else $error("run bits wrong");

    // Main scenarios reached
    cover property (pulse_m && pto_ff && !ext_cutoff_irq_pin_n);
    cover property (cmp_m && opt_ff == 2'h3 && cmp_overcurrent);
    cover property (ch1_underflow && mode_ff == pce_pkg::MODE_COMPL);
endmodule

bind pce_cutoff_top pce_cutoff_sva pce_cutoff_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .ext_cutoff_irq_pin_n(ext_cutoff_irq_pin_n), .cmp_overcurrent(cmp_overcurrent), .cap_edge(cap_edge),
    .cmp_match(cmp_match), .ch1_underflow(ch1_underflow), .pin_out(pin_out), .pin_oe(pin_oe),
    .count_run(count_run), .link_event(link_event));

// ### verif/pce_far_model.sv
/* Far-side model: fault pin, comparator, events and timer pulses.
   Assumes tasks are called after a rising edge. */
`timescale 1ns/1ps

module pce_far_model (
    // Clock and run bits
    input logic pclk,
    input logic [1:0] count_run,
    // Sources
    output logic ext_cutoff_irq_pin_n,
    output logic cmp_overcurrent,
    output logic event_in0,
    output logic event_in1,
    // Timer side
    output logic [7:0] timer_wave,
    output logic [15:0] counter0,
    output logic [15:0] counter1,
    output logic [3:0] cap_edge,
    output logic [3:0] cmp_match,
    output logic ch1_underflow
);
    // Pin pulled up; waveform fixed so forced levels stand out
    initial begin
        ext_cutoff_irq_pin_n = 1'b1;
        {cmp_overcurrent, event_in0, event_in1, cap_edge, cmp_match, ch1_underflow} = 12'h0;
        timer_wave = 8'h55;
        counter0 = 16'h1234;
        counter1 = 16'h5a3c;
    end

    // Counters run with their run bits
    always @(posedge pclk) begin
        counter0 <= counter0 + {15'h0, count_run[0]};
        counter1 <= counter1 + {15'h0, count_run[1]};
    end

    // Pin holds its level
    task automatic set_ext(input logic v);
        @(posedge pclk);
        ext_cutoff_irq_pin_n <= v;
    endtask

    // One-cycle pulses
    task automatic pulse(input logic [3:0] c, m, input logic u, input logic [1:0] e, input logic o);
        @(posedge pclk);
        {cap_edge, cmp_match, ch1_underflow, event_in1, event_in0, cmp_overcurrent} <= {c, m, u, e, o};
        @(posedge pclk);
        {cap_edge, cmp_match, ch1_underflow, event_in1, event_in0, cmp_overcurrent} <= 12'h0;
    endtask
endmodule

// ### verif/pce_cutoff_top_tb.sv
/* Testbench for the cutoff block.
   Assumes the far model drives all sources. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", n, e, g); end end

module pce_cutoff_top_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ext_n, cmp_ov, ev0, ev1, uf;
    logic [7:0] paddr, wave, pin_out, pin_oe;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnt0, cnt1;
    logic [3:0] cap, cmpm;
    logic [1:0] count_run;
    logic [4:0] link_event;
    int n_fail = 0;
    int checks_done = 0;
    // Mode and expected events for cap 5, match a, underflow
    logic [7:0] rows [6] = '{{pce_pkg::MODE_CAPTURE, 5'h05}, {pce_pkg::MODE_COMPARE, 5'h0a},
        {pce_pkg::MODE_PWM, 5'h0a}, {pce_pkg::MODE_RSYNC, 5'h0a}, {pce_pkg::MODE_COMPL, 5'h1a},
        {pce_pkg::MODE_TRI, 5'h0a}};

    pce_cutoff_top pce_cutoff_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_cutoff_irq_pin_n(ext_n), .cmp_overcurrent(cmp_ov), .event_in0(ev0), .event_in1(ev1),
        .timer_wave(wave), .counter0(cnt0), .counter1(cnt1), .cap_edge(cap), .cmp_match(cmpm),
        .ch1_underflow(uf), .pin_out(pin_out), .pin_oe(pin_oe), .count_run(count_run), .link_event(link_event));
    pce_far_model pce_far_model_i (.pclk(pclk), .count_run(count_run), .ext_cutoff_irq_pin_n(ext_n),
        .cmp_overcurrent(cmp_ov), .event_in0(ev0), .event_in1(ev1), .timer_wave(wave), .counter0(cnt0),
        .counter1(cnt1), .cap_edge(cap), .cmp_match(cmpm), .ch1_underflow(uf));

    always #5 pclk = ~pclk;

    // Hang guard: counts as a mismatch
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        conclude();
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        for (n = 0; pready !== 1'b1 && n < 16; n++) begin
            @(posedge pclk);
            #1;
        end
        if (pready !== 1'b1) begin
            n_fail++;
            conclude();
        end
        {rd, err} = {prdata, pslverr};
        @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask

    task automatic mode(input logic [2:0] m);
        wr(pce_pkg::ADDR_FUNC, {29'h0, m});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        `CHK("read data", e, rd & m)
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // Pins settle one edge after their cause, two after an event or comparator input
    task automatic pins(input logic [7:0] oe, input logic [7:0] o);
        step(2);
        `CHK("pin_oe", oe, pin_oe)
        `CHK("pin_out", o, pin_out & pin_oe)
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = 45'h0;
        step(15);
        `CHK("pin_oe", 8'h00, pin_oe)
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(pce_pkg::ADDR_OUT_EN, 32'hff, 32'hff);
        rchk(8'h30, 32'h0, 32'hffffffff);
        `CHK("pslverr", 1'b1, err)
        $display("test reset done");
        // Event routing per mode
        for (int i = 0; i < 6; i++) begin
            mode(rows[i][7:5]);
            pce_far_model_i.pulse(4'h5, 4'ha, 1'b1, 2'b00, 1'b0);
            #1;
            `CHK("link_event", rows[i][4:0], link_event)
        end
        $display("test events done");
        // Pin cutoff: A0 low, B0 high, C0 and D0 hi-Z, channel 1 low
        mode(pce_pkg::MODE_PWM);
        wr(pce_pkg::ADDR_OUT_EN, 32'hf0);
        pins(8'h0f, 8'h05);
        wr(pce_pkg::ADDR_OUT_EN, 32'h00);
        wr(pce_pkg::ADDR_LVL0, 32'h4e);
        wr(pce_pkg::ADDR_LVL1, 32'haa);
        wr(pce_pkg::ADDR_CUT_CTRL, 32'h01);
        pins(8'hff, 8'h55);
        pce_far_model_i.set_ext(1'b0);
        pins(8'hf3, 8'h02);
        rchk(pce_pkg::ADDR_CUT_CTRL, 32'h80, 32'h80);
        pce_far_model_i.set_ext(1'b1);
        pins(8'hff, 8'h55);
        mode(pce_pkg::MODE_COMPARE);
        pce_far_model_i.set_ext(1'b0);
        pins(8'hff, 8'h55);
        pce_far_model_i.set_ext(1'b1);
        wr(pce_pkg::ADDR_CUT_CTRL, 32'h01);
        rchk(pce_pkg::ADDR_CUT_CTRL, 32'h0, 32'h80);
        $display("test pin cutoff done");
        // Event cutoff latches; release refused while counting
        mode(pce_pkg::MODE_PWM);
        wr(pce_pkg::ADDR_ELINK, 32'h05);
        pce_far_model_i.pulse(4'h0, 4'h0, 1'b0, 2'b01, 1'b0);
        pins(8'hf3, 8'h02);
        step(20);
        pins(8'hf3, 8'h02);
        rchk(pce_pkg::ADDR_CUT_CTRL, 32'h80, 32'h80);
        wr(pce_pkg::ADDR_RUN, 32'h01);
        step(1);
        `CHK("count_run", 2'b01, count_run)
        wr(pce_pkg::ADDR_CUT_CTRL, 32'h01);
        pins(8'hf3, 8'h02);
        wr(pce_pkg::ADDR_RUN, 32'h00);
        wr(pce_pkg::ADDR_CUT_CTRL, 32'h01);
        pins(8'hff, 8'h55);
        rchk(pce_pkg::ADDR_CH_STAT, 32'h0, 32'h3);
        $display("test event cutoff done");
        // Event capture, no cutoff in capture mode
        mode(pce_pkg::MODE_CAPTURE);
        wr(pce_pkg::ADDR_ELINK, 32'h0f);
        pce_far_model_i.pulse(4'h0, 4'h0, 1'b0, 2'b10, 1'b0);
        step(1);
        rchk(pce_pkg::ADDR_CAP1, {16'h0, pce_far_model_i.counter1}, 32'hffff);
        rchk(pce_pkg::ADDR_CH_STAT, 32'h2, 32'h3);
        rchk(pce_pkg::ADDR_CUT_CTRL, 32'h0, 32'h80);
        $display("test capture done");
        // Comparator cutoff: all pins hi-Z
        mode(pce_pkg::MODE_RSYNC);
        wr(pce_pkg::ADDR_OPTION, 32'h03);
        pce_far_model_i.pulse(4'h0, 4'h0, 1'b0, 2'b00, 1'b1);
        pins(8'h00, 8'h00);
        wr(pce_pkg::ADDR_CUT_CTRL, 32'h01);
        pins(8'hff, 8'h55);
        $display("test comparator done");
        conclude();
    end
endmodule
